// File: core/pcgen_map.vh
`ifndef PCGEN_MAP_VH
`define PCGEN_MAP_VH

// register offsets (byte addresses on the plain register port)
`define PCGEN_ADDR_W 8
`define PCGEN_OFS_CHIP_CFG 8'h00
`define PCGEN_OFS_PIN_CFG 8'h04
`define PCGEN_OFS_STATUS 8'h08

// chip_config_reg fields
`define PCGEN_DIVSEL_LSB 0
`define PCGEN_DIVSEL_MSB 2
`define PCGEN_DIVSEL_BIT0_RST 1'b0

// pin_config_reg fields
`define PCGEN_GATE_LSB 0
`define PCGEN_GATE_MSB 5
`define PCGEN_GATE_RST 6'h3F

// status register fields
`define PCGEN_ST_CODE_LSB 0
`define PCGEN_ST_CODE_MSB 2
`define PCGEN_ST_RATIO_LSB 4
`define PCGEN_ST_RATIO_MSB 7
`define PCGEN_ST_LOCK_BIT 8
`define PCGEN_ST_STRAP_LSB 12
`define PCGEN_ST_STRAP_MSB 15

// divide select codes
`define PCGEN_CODE_000 3'h0
`define PCGEN_CODE_001 3'h1
`define PCGEN_CODE_010 3'h2
`define PCGEN_CODE_011 3'h3
`define PCGEN_CODE_100 3'h4
`define PCGEN_CODE_101 3'h5
`define PCGEN_CODE_110 3'h6
`define PCGEN_CODE_111 3'h7

// core clock divide ratios
`define PCGEN_RATIO_4 4'h4
`define PCGEN_RATIO_5 4'h5
`define PCGEN_RATIO_8 4'h8
`define PCGEN_RATIO_9 4'h9
`define PCGEN_RATIO_10 4'hA
`define PCGEN_RATIO_11 4'hB

// divider count at reset: the first edge after release closes a period
`define PCGEN_DIV_CNT_RST 4'h3

// feedback period measurement
`define PCGEN_FB_CNT_W 8
`define PCGEN_FB_CNT_MAX 8'hFF
`define PCGEN_FB_MIN_PERIOD 8'h02

`endif

// File: core/pcgen_div.v
`timescale 1ns/100ps
`include "pcgen_map.vh"

module pcgen_div (
    // clock and reset
    input wire clk_in,
    input wire rst_n_in,
    // ratio control
    input wire [3:0] ratio_in,
    // divided clock, period end and active ratio
    output reg clk_div_out,
    output wire wrap_out,
    output wire [3:0] ratio_out
);

reg [3:0] cnt_r;
reg [3:0] ratio_r;
wire [3:0] last_cnt;
wire [3:0] half_cnt;

assign last_cnt = ratio_r - 4'h1;
assign half_cnt = {1'b0, ratio_r[3:1]};
assign wrap_out = (cnt_r == last_cnt);
assign ratio_out = ratio_r;

// new ratio only taken at period end, so no runt pulse on a change
always @(posedge clk_in or negedge rst_n_in)
begin
    if (!rst_n_in)
    begin
        // starting mid count would give a short first period after reset
        cnt_r <= `PCGEN_DIV_CNT_RST;
        ratio_r <= `PCGEN_RATIO_4;
        clk_div_out <= 1'b0;
    end
    else
    begin
        if (wrap_out)
        begin
            cnt_r <= 4'h0;
            ratio_r <= ratio_in;
            clk_div_out <= 1'b1;
        end
        else
        begin
            cnt_r <= cnt_r + 4'h1;
            // odd ratios: high half one cycle shorter than low half
            clk_div_out <= ((cnt_r + 4'h1) < half_cnt);
        end
    end
end

endmodule // pcgen_div

// File: core/pcgen_top.v
// The register addresses and the strobed register port were chosen for this implementation.
`timescale 1ns/100ps
`include "pcgen_map.vh"

module pcgen_top (
    // clock and reset
    input wire CLK_SYS_IN,
    input wire RST_N_IN,
    // boot straps
    input wire [1:0] STRAP_PCI_DIV_IN,
    input wire [3:0] STRAP_CORE_MULT_IN,
    // register port
    input wire [7:0] REG_ADDR_IN,
    input wire [31:0] REG_WDATA_IN,
    input wire REG_WR_IN,
    input wire REG_RD_IN,
    output reg [31:0] REG_RDATA_OUT,
    // bus clocks and feedback
    output reg [5:0] PCI_BUS_CLOCK_OUT,
    input wire PCI_CLOCK_FEEDBACK_IN,
    // controller clock and deskew lock
    output reg PCI_CONTROLLER_CLOCK_OUT,
    output wire PCI_DESKEW_LOCK_OUT
);

// code to ratio lookup, feeds the divider; status shows the divider's active ratio
function [3:0] pcgen_ratio;
    input [2:0] code;
    begin
        case (code)
            `PCGEN_CODE_001: pcgen_ratio = `PCGEN_RATIO_4;
            `PCGEN_CODE_011: pcgen_ratio = `PCGEN_RATIO_4;
            `PCGEN_CODE_111: pcgen_ratio = `PCGEN_RATIO_5;
            `PCGEN_CODE_101: pcgen_ratio = `PCGEN_RATIO_5;
            `PCGEN_CODE_000: pcgen_ratio = `PCGEN_RATIO_8;
            `PCGEN_CODE_010: pcgen_ratio = `PCGEN_RATIO_9;
            `PCGEN_CODE_100: pcgen_ratio = `PCGEN_RATIO_10;
            `PCGEN_CODE_110: pcgen_ratio = `PCGEN_RATIO_11;
            default: pcgen_ratio = `PCGEN_RATIO_4;
        endcase
    end
endfunction

// address match, shared by the two write decodes
function pcgen_hit;
    input [7:0] addr;
    input [7:0] ofs;
    begin
        pcgen_hit = (addr == ofs);
    end
endfunction

// strap capture state
localparam ST_CAPTURE = 1'b0;
localparam ST_RUN = 1'b1;

reg state_r;
reg [2:0] pci_divide_select_r;
reg [5:0] pci_out_gate_bits_r;
reg [5:0] gate_live_r;
reg [3:0] core_mult_strap_r;
wire [3:0] div_ratio;
wire [3:0] active_ratio;
wire div_clk;
wire div_wrap;
wire wr_chip_cfg;
wire wr_pin_cfg;

assign wr_chip_cfg = REG_WR_IN && pcgen_hit(REG_ADDR_IN, `PCGEN_OFS_CHIP_CFG);
assign wr_pin_cfg = REG_WR_IN && pcgen_hit(REG_ADDR_IN, `PCGEN_OFS_PIN_CFG);

// straps are taken on the first edge after release, never under reset
reg state_nxt;
reg [2:0] pci_divide_select_nxt;
reg [3:0] core_mult_strap_nxt;

always @*
begin
    state_nxt = state_r;
    pci_divide_select_nxt = pci_divide_select_r;
    core_mult_strap_nxt = core_mult_strap_r;
    case (state_r)
        ST_CAPTURE:
        begin
            state_nxt = ST_RUN;
            // upper bits from straps, bit 0 forced low
            pci_divide_select_nxt = {STRAP_PCI_DIV_IN, `PCGEN_DIVSEL_BIT0_RST};
            // multiplier only recorded; the core clock arrives ready made
            core_mult_strap_nxt = STRAP_CORE_MULT_IN;
        end
        ST_RUN:
        begin
            // straps not looked at again until the next reset
            if (wr_chip_cfg)
            begin
                pci_divide_select_nxt =
                    REG_WDATA_IN[`PCGEN_DIVSEL_MSB:`PCGEN_DIVSEL_LSB];
            end
        end
        default:
        begin
            state_nxt = ST_CAPTURE;
        end
    endcase
end

always @(posedge CLK_SYS_IN or negedge RST_N_IN)
begin
    if (!RST_N_IN)
    begin
        state_r <= ST_CAPTURE;
        pci_divide_select_r <= {2'h0, `PCGEN_DIVSEL_BIT0_RST};
        core_mult_strap_r <= 4'h0;
    end
    else
    begin
        state_r <= state_nxt;
        pci_divide_select_r <= pci_divide_select_nxt;
        core_mult_strap_r <= core_mult_strap_nxt;
    end
end

// output gates
reg [5:0] pci_out_gate_bits_nxt;
reg [5:0] gate_live_nxt;

always @*
begin
    pci_out_gate_bits_nxt = pci_out_gate_bits_r;
    gate_live_nxt = gate_live_r;
    if (wr_pin_cfg)
    begin
        pci_out_gate_bits_nxt = REG_WDATA_IN[`PCGEN_GATE_MSB:`PCGEN_GATE_LSB];
    end
    // gate applied at period start so an output never gets a sliver
    if (div_wrap)
    begin
        gate_live_nxt = pci_out_gate_bits_r;
    end
end

always @(posedge CLK_SYS_IN or negedge RST_N_IN)
begin
    if (!RST_N_IN)
    begin
        pci_out_gate_bits_r <= `PCGEN_GATE_RST;
        gate_live_r <= `PCGEN_GATE_RST;
    end
    else
    begin
        pci_out_gate_bits_r <= pci_out_gate_bits_nxt;
        gate_live_r <= gate_live_nxt;
    end
end

assign div_ratio = pcgen_ratio(pci_divide_select_r);

pcgen_div i_pcgen_div (
    .clk_in(CLK_SYS_IN),
    .rst_n_in(RST_N_IN),
    .ratio_in(div_ratio),
    .clk_div_out(div_clk),
    .wrap_out(div_wrap),
    .ratio_out(active_ratio)
);

// six gated copies from flip-flops, all in step
wire [5:0] bus_clk_nxt;

assign bus_clk_nxt = {6{div_clk}} & gate_live_r;

always @(posedge CLK_SYS_IN or negedge RST_N_IN)
begin
    if (!RST_N_IN)
    begin
        PCI_BUS_CLOCK_OUT <= 6'h00;
    end
    else
    begin
        PCI_BUS_CLOCK_OUT <= bus_clk_nxt;
    end
end

// deskew stage: feedback follows the board loop back
reg fb_r;
reg fb_prev_r;
reg [7:0] fb_cnt_r;
reg [7:0] fb_period_r;
reg fb_lock_r;
wire fb_rise;

assign fb_rise = fb_r && !fb_prev_r;
assign PCI_DESKEW_LOCK_OUT = fb_lock_r;

// regenerated clock tracks the input rate; fixed latency of two edges
always @(posedge CLK_SYS_IN or negedge RST_N_IN)
begin
    if (!RST_N_IN)
    begin
        fb_r <= 1'b0;
        fb_prev_r <= 1'b0;
        PCI_CONTROLLER_CLOCK_OUT <= 1'b0;
    end
    else
    begin
        fb_r <= PCI_CLOCK_FEEDBACK_IN;
        fb_prev_r <= fb_r;
        PCI_CONTROLLER_CLOCK_OUT <= fb_r;
    end
end

// lock when two feedback periods in a row match; lost if feedback stops
reg [7:0] fb_cnt_nxt;
reg [7:0] fb_period_nxt;
reg fb_lock_nxt;

always @*
begin
    fb_cnt_nxt = fb_cnt_r;
    fb_period_nxt = fb_period_r;
    fb_lock_nxt = fb_lock_r;
    if (fb_rise)
    begin
        fb_cnt_nxt = 8'h01;
        fb_period_nxt = fb_cnt_r;
        fb_lock_nxt = (fb_cnt_r == fb_period_r) &&
                      (fb_cnt_r >= `PCGEN_FB_MIN_PERIOD);
    end
    else if (fb_cnt_r != `PCGEN_FB_CNT_MAX)
    begin
        fb_cnt_nxt = fb_cnt_r + 8'h01;
    end
    else
    begin
        // feedback gone: forget the period so a restart relocks cleanly
        fb_lock_nxt = 1'b0;
        fb_period_nxt = 8'h00;
    end
end

always @(posedge CLK_SYS_IN or negedge RST_N_IN)
begin
    if (!RST_N_IN)
    begin
        fb_cnt_r <= 8'h00;
        fb_period_r <= 8'h00;
        fb_lock_r <= 1'b0;
    end
    else
    begin
        fb_cnt_r <= fb_cnt_nxt;
        fb_period_r <= fb_period_nxt;
        fb_lock_r <= fb_lock_nxt;
    end
end

// register read, data in the cycle after the strobe; unmapped reads zero
reg [31:0] rd_nxt;

always @*
begin
    rd_nxt = 32'h00000000;
    case (REG_ADDR_IN)
        `PCGEN_OFS_CHIP_CFG:
            rd_nxt[`PCGEN_DIVSEL_MSB:`PCGEN_DIVSEL_LSB] = pci_divide_select_r;
        `PCGEN_OFS_PIN_CFG:
            rd_nxt[`PCGEN_GATE_MSB:`PCGEN_GATE_LSB] = pci_out_gate_bits_r;
        `PCGEN_OFS_STATUS:
        begin
            rd_nxt[`PCGEN_ST_CODE_MSB:`PCGEN_ST_CODE_LSB] = pci_divide_select_r;
            rd_nxt[`PCGEN_ST_RATIO_MSB:`PCGEN_ST_RATIO_LSB] = active_ratio;
            rd_nxt[`PCGEN_ST_LOCK_BIT] = fb_lock_r;
            rd_nxt[`PCGEN_ST_STRAP_MSB:`PCGEN_ST_STRAP_LSB] = core_mult_strap_r;
        end
        default:
            rd_nxt = 32'h00000000;
    endcase
end

always @(posedge CLK_SYS_IN or negedge RST_N_IN)
begin
    if (!RST_N_IN)
    begin
        REG_RDATA_OUT <= 32'h00000000;
    end
    else if (REG_RD_IN)
    begin
        REG_RDATA_OUT <= rd_nxt;
    end
    else
    begin
        REG_RDATA_OUT <= 32'h00000000;
    end
end

endmodule // pcgen_top

// File: sim/pcgen_board.sv
`timescale 1ns/100ps
module pcgen_board #(
    parameter SEL = 0
) (
    // bus clocks from the device
    input wire [5:0] bus_clk_in,
    // looped feedback trace
    output wire fb_out
);
    // plain trace back, so feedback phase equals the chosen output
    assign fb_out = bus_clk_in[SEL];
endmodule // pcgen_board

// File: sim/pcgen_properties.sv
`timescale 1ns/100ps
module pcgen_chk (
    // all top ports, watched only
    input wire CLK_SYS_IN,
    input wire RST_N_IN,
    input wire [1:0] STRAP_PCI_DIV_IN,
    input wire [3:0] STRAP_CORE_MULT_IN,
    input wire [7:0] REG_ADDR_IN,
    input wire [31:0] REG_WDATA_IN,
    input wire REG_WR_IN,
    input wire REG_RD_IN,
    input wire [31:0] REG_RDATA_OUT,
    input wire [5:0] PCI_BUS_CLOCK_OUT,
    input wire PCI_CLOCK_FEEDBACK_IN,
    input wire PCI_CONTROLLER_CLOCK_OUT,
    input wire PCI_DESKEW_LOCK_OUT
);
    reg [7:0] rc_r;
    reg [3:0] pc_r;
    reg wc_r;
    reg on_d_r;
    wire bus_on = |PCI_BUS_CLOCK_OUT;
    always @(posedge CLK_SYS_IN or negedge RST_N_IN)
        if (!RST_N_IN)
        begin
            rc_r <= 8'h00;
            pc_r <= 4'hF;
            wc_r <= 1'b0;
            on_d_r <= 1'b0;
        end
        else
        begin
            if (rc_r != 8'hFF)
                rc_r <= rc_r + 8'h01;
            // starts saturated so the first rise after reset is not judged
            if (bus_on && !on_d_r)
                pc_r <= 4'h0;
            else if (pc_r != 4'hF)
                pc_r <= pc_r + 4'h1;
            wc_r <= wc_r | (REG_WR_IN && REG_ADDR_IN == 8'h00);
            on_d_r <= bus_on;
        end
    default clocking cb @(posedge CLK_SYS_IN); endclocking
    default disable iff (!RST_N_IN);
    AST_RD_IDLE: assert property (!$past(REG_RD_IN) |-> REG_RDATA_OUT == 32'h0)
        else $error("read data not zero outside answer");
    AST_ST_BITS: assert property ($past(REG_RD_IN) && $past(REG_ADDR_IN) == 8'h08
        |-> REG_RDATA_OUT[31:9] == {16'h0, $past(STRAP_CORE_MULT_IN), 3'h0})
        else $error("status strap field wrong");
    AST_CFG_RST: assert property ($past(REG_RD_IN) && $past(REG_ADDR_IN) == 8'h00
        && !wc_r |-> REG_RDATA_OUT == {29'h0, STRAP_PCI_DIV_IN, 1'b0})
        else $error("divide select reset value wrong");
    AST_FB_COPY: assert property (rc_r > 8'h02
        |-> PCI_CONTROLLER_CLOCK_OUT == $past(PCI_CLOCK_FEEDBACK_IN, 2))
        else $error("controller clock not feedback copy");
    AST_INPHASE: assert property ($past(bus_on)
        |-> (PCI_BUS_CLOCK_OUT & ~$past(PCI_BUS_CLOCK_OUT)) == 6'h00)
        else $error("bus clocks out of phase");
    AST_HIGH: assert property ($rose(bus_on) |-> ##[1:5] !bus_on)
        else $error("bus clock high too long");
    AST_PERIOD: assert property ($rose(bus_on) |-> pc_r >= 4'h3)
        else $error("bus clock period below four");
    AST_LOCK: assert property (rc_r == 8'd120 |-> PCI_DESKEW_LOCK_OUT)
        else $error("deskew not locked");
    cover property ($rose(PCI_DESKEW_LOCK_OUT));
    cover property ($past(REG_RD_IN) && $past(REG_ADDR_IN) == 8'h08);
    cover property (PCI_BUS_CLOCK_OUT == 6'h15);
    cover property ($fell(PCI_DESKEW_LOCK_OUT));
endmodule // pcgen_chk
bind pcgen_top pcgen_chk i_pcgen_chk (.*);

// File: sim/test_pcgen_top.sv
`timescale 1ns/100ps
module test_pcgen_top;
    logic CLK_SYS_IN = 1'b0;
    logic RST_N_IN = 1'b0;
    logic [1:0] STRAP_PCI_DIV_IN = 2'h1;
    logic [3:0] STRAP_CORE_MULT_IN = 4'hA;
    logic [7:0] REG_ADDR_IN = 8'h00;
    logic [31:0] REG_WDATA_IN = 32'h0;
    logic REG_WR_IN = 1'b0;
    logic REG_RD_IN = 1'b0;
    wire [31:0] REG_RDATA_OUT;
    wire [5:0] PCI_BUS_CLOCK_OUT;
    wire PCI_CLOCK_FEEDBACK_IN;
    wire PCI_CONTROLLER_CLOCK_OUT;
    wire PCI_DESKEW_LOCK_OUT;
    integer fails = 0;
    integer checks = 0;
    integer cnt;
    logic [31:0] d;
    logic [7:0] p, h;
    logic [5:0] sn;
    logic [3:0] rt [8] = '{4'h8, 4'h4, 4'h9, 4'h4, 4'hA, 4'h5, 4'hB, 4'h5};
    pcgen_top i_pcgen_top (.*);
    pcgen_board i_pcgen_board (.bus_clk_in(PCI_BUS_CLOCK_OUT), .fb_out(PCI_CLOCK_FEEDBACK_IN));
    always #20 CLK_SYS_IN = ~CLK_SYS_IN;
    task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        begin
            checks++;
            if (s !== e)
            begin
                fails++;
                $display("[ERR] %s exp %h saw %h", nm, e, s);
            end
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] v);
        begin
            @(posedge CLK_SYS_IN);
            REG_ADDR_IN <= a;
            REG_WDATA_IN <= v;
            REG_WR_IN <= 1'b1;
            @(posedge CLK_SYS_IN);
            REG_WR_IN <= 1'b0;
        end
    endtask
    task rd(input logic [7:0] a);
        begin
            @(posedge CLK_SYS_IN);
            REG_ADDR_IN <= a;
            REG_RD_IN <= 1'b1;
            @(posedge CLK_SYS_IN);
            REG_RD_IN <= 1'b0;
            #1;
            d = REG_RDATA_OUT;
        end
    endtask
    task step;
        begin
            @(posedge CLK_SYS_IN);
            #1;
            cnt++;
        end
    endtask
    // measures one full period of output 0, starting at a rise
    task per;
        begin
            cnt = 0;
            // keep clear of the edge that launches the outputs
            #1;
            while (PCI_BUS_CLOCK_OUT[0] !== 1'b0 && cnt < 40)
                step;
            while (PCI_BUS_CLOCK_OUT[0] !== 1'b1 && cnt < 80)
                step;
            cnt = 0;
            while (PCI_BUS_CLOCK_OUT[0] === 1'b1 && cnt < 20)
                step;
            h = cnt[7:0];
            while (PCI_BUS_CLOCK_OUT[0] === 1'b0 && cnt < 20)
                step;
            p = cnt[7:0];
        end
    endtask
    task give_verdict;
        begin
            if (fails == 0 && checks > 0)
                $display("Run complete: PASS");
            else
                $display("Run complete: FAIL");
            $finish;
        end
    endtask
    initial
    begin
        #200000;
        fails++;
        give_verdict;
    end
    initial
    begin
        repeat (2) @(posedge CLK_SYS_IN);
        RST_N_IN <= 1'b1;
        // let the deskew lock settle before any ratio change
        repeat (120) @(posedge CLK_SYS_IN);
        rd(8'h00);
        chk("div select", d, 32'h2);
        rd(8'h04);
        chk("gates", d, 32'h3F);
        rd(8'h08);
        chk("status", d, 32'hA192);
        rd(8'h0C);
        chk("unmapped", d, 32'h0);
        wr(8'h08, 32'h5);
        rd(8'h00);
        chk("ro status", d, 32'h2);
        for (int c = 0; c < 8; c++)
        begin
            wr(8'h00, c);
            per;
            per;
            chk("period", p, rt[c]);
            chk("high", h, rt[c] >> 1);
            rd(8'h08);
            chk("ratio", d[7:4], rt[c]);
        end
        wr(8'h04, 32'h15);
        // first period may still carry the old gates
        per;
        per;
        sn = 6'h00;
        repeat (12)
        begin
            step;
            sn = sn | PCI_BUS_CLOCK_OUT;
        end
        chk("gating", sn, 6'h15);
        // feedback trace carries output 0; gating it off must drop the lock
        wr(8'h04, 32'h3E);
        repeat (300) @(posedge CLK_SYS_IN);
        rd(8'h08);
        chk("lock lost", d[8], 1'b0);
        @(posedge CLK_SYS_IN);
        RST_N_IN <= 1'b0;
        STRAP_PCI_DIV_IN <= 2'h3;
        @(posedge CLK_SYS_IN);
        RST_N_IN <= 1'b1;
        rd(8'h00);
        chk("strap 11", d, 32'h6);
        rd(8'h04);
        chk("gates rst", d, 32'h3F);
        per;
        per;
        chk("period 11", p, 32'hB);
        give_verdict;
    end
endmodule // test_pcgen_top
